// >>> tob_glitch_filter.sv
`timescale 1ns/1ps

module tob_glitch_filter
  import tob_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic raw_i,
  input wire logic [1:0] polarity_i,
  input wire logic [2:0] width_sel_i,
  output logic filt_o
);

  logic filt_q, filt_d;
  logic [1:0] cnt_q, cnt_d;
  logic [1:0] need;
  logic block;
  tob_flt_mode_t mode;

  // ****************************************
  // Filter next state
  // ****************************************
  always_comb begin
    mode = tob_flt_mode_t'(polarity_i);
    need = tob_gw_cycles(width_sel_i);
    unique case (mode)
      TOB_FLT_OFF: block = 1'b0;
      TOB_FLT_LOW: block = filt_q;
      TOB_FLT_HIGH: block = ~filt_q;
      TOB_FLT_BOTH: block = 1'b1;
    endcase
    filt_d = filt_q;
    cnt_d = 2'h0;
    if (raw_i != filt_q) begin
      if (!block || cnt_q >= need - 2'h1) begin
        filt_d = raw_i;
      end else begin
        cnt_d = cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (ce_i) begin
      filt_q <= filt_d;
      cnt_q <= cnt_d;
    end
  end

  assign filt_o = filt_q;

endmodule

// >>> tob_pkg.sv
package tob_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int TOB_DW = 32;
  localparam int TOB_AW = 10;
  localparam int TOB_IDX_W = 8;
  localparam int TOB_TRIM_W = 8;

  // ****************************************
  // Register indices (byte address = 4 x index)
  // ****************************************
  localparam logic [7:0] TOB_IDX_ADC_REF = 8'h20;
  localparam logic [7:0] TOB_IDX_ADC_CMP = 8'h21;
  localparam logic [7:0] TOB_IDX_OSC = 8'h22;
  localparam logic [7:0] TOB_IDX_BROWNOUT = 8'h23;
  localparam logic [7:0] TOB_IDX_CLK_FLT = 8'h26;
  localparam logic [7:0] TOB_IDX_STATUS = 8'h27;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [7:0] TOB_RST_ADC_REF = 8'hFF;
  localparam logic [7:0] TOB_RST_ADC_CMP = 8'hFF;
  localparam logic [7:0] TOB_RST_OSC = 8'h80;
  localparam logic [7:0] TOB_RST_BROWNOUT = 8'hFC;
  localparam logic [7:0] TOB_RST_CLK_FLT = 8'h44;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TOB_ADC_REF_LSB = 3;
  localparam int TOB_BO_CODE_MSB = 2;
  localparam int TOB_QR_BIT = 7;
  localparam int TOB_GW_MSB = 5;
  localparam int TOB_GW_LSB = 3;
  localparam int TOB_POL_MSB = 1;
  localparam int TOB_ST_BO_UNDEF = 0;
  localparam int TOB_ST_FILT = 1;
  localparam int TOB_ST_OUT = 2;
  localparam int TOB_ST_POL_LSB = 4;

  // ****************************************
  // Brown-out codes and one-hot selection slots
  // ****************************************
  localparam logic [2:0] TOB_BO_1V7 = 3'h0;
  localparam logic [2:0] TOB_BO_1V6 = 3'h1;
  localparam logic [2:0] TOB_BO_1V8 = 3'h7;
  localparam logic [2:0] TOB_BO_2V0 = 3'h6;
  localparam logic [2:0] TOB_BO_2V2 = 3'h5;
  localparam logic [2:0] TOB_BO_2V4 = 3'h4;
  localparam int TOB_BO_SEL_W = 6;

  // ****************************************
  // Glitch widths
  // ****************************************
  localparam int TOB_CLK_MHZ = 100;
  localparam int TOB_GW_NS [8] = '{5, 7, 9, 11, 13, 17, 20, 25};
  localparam int TOB_GW_CNT_W = 2;

  typedef enum logic [1:0] {
    TOB_FLT_OFF,
    TOB_FLT_LOW,
    TOB_FLT_HIGH,
    TOB_FLT_BOTH
  } tob_flt_mode_t;

  // Least time: round up, never below one cycle
  function automatic logic [1:0] tob_gw_cycles(input logic [2:0] sel);
    int cyc;
    cyc = (TOB_GW_NS[sel] * TOB_CLK_MHZ + 999) / 1000;
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc[1:0];
  endfunction

  // One-hot: 1.6, 1.7, 1.8, 2.0, 2.2, 2.4; zero for undefined
  function automatic logic [5:0] tob_bo_decode(input logic [2:0] code);
    logic [5:0] sel;
    sel = 6'h00;
    unique case (code)
      TOB_BO_1V6: sel = 6'h01;
      TOB_BO_1V7: sel = 6'h02;
      TOB_BO_1V8: sel = 6'h04;
      TOB_BO_2V0: sel = 6'h08;
      TOB_BO_2V2: sel = 6'h10;
      TOB_BO_2V4: sel = 6'h20;
      default: sel = 6'h00;
    endcase
    return sel;
  endfunction

endpackage

// >>> tob_quarter_rate.sv
`timescale 1ns/1ps

module tob_quarter_rate
  import tob_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic in_i,
  input wire logic quarter_i,
  output logic out_o
);

  logic prev_q, prev_d;
  logic half_q, half_d;
  logic out_q, out_d;

  // ****************************************
  // Divider next state
  // ****************************************
  always_comb begin
    prev_d = in_i;
    half_d = half_q;
    out_d = out_q;
    if (!quarter_i) begin
      out_d = in_i;
      half_d = 1'b0;
    end else if (in_i && !prev_q) begin
      half_d = ~half_q;
      if (half_q) begin
        out_d = ~out_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
      half_q <= 1'b0;
      out_q <= 1'b0;
    end else if (ce_i) begin
      prev_q <= prev_d;
      half_q <= half_d;
      out_q <= out_d;
    end
  end

  assign out_o = out_q;

endmodule

// >>> tob_trim_bank.sv
`timescale 1ns/1ps

// Summary of operation
// - Trim indices 20h,21h,22h,23h,26h map to ADC ref, ADC/comp, oscillator, brown-out, filter.
// - Trim bytes sit at locations 20h to 26h, one byte each.
// - Full oscillator byte drives the oscillator adjust value.
// - Brown-out code selects one of six thresholds; 010, 011 undefined.
// - Filter bit 7 low passes clock; high gives quarter frequency.
// - Filter bits 5:3 select widest glitch removed.
// - Filter bits 1:0: none, low glitches, high glitches, both.
// - Width codes 000..111 give 5,7,9,11,13,17,20,25 ns.

module tob_trim_bank
  import tob_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic clk_filter_in_i,
  output logic clk_filter_out_o,
  output logic [4:0] adc_reference_adjust_value_o,
  output logic [7:0] adc_comparator_adjust_o,
  output logic [7:0] oscillator_adjust_value_o,
  output logic [5:0] brownout_threshold_sel_o,
  output logic brownout_code_undefined_o,
  output logic quarter_rate_select_o,
  output logic [2:0] glitch_width_select_o,
  output logic [1:0] glitch_filter_polarity_o
);

  // ****************************************
  // Declarations
  // ****************************************
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] adc_ref_q, adc_ref_d;
  logic [7:0] adc_cmp_q, adc_cmp_d;
  logic [7:0] osc_q, osc_d;
  logic [7:0] bo_q, bo_d;
  logic [7:0] flt_q, flt_d;
  logic [4:0] ref_out_q, ref_out_d;
  logic [7:0] cmp_out_q, cmp_out_d;
  logic [7:0] osc_out_q, osc_out_d;
  logic [5:0] bo_sel_q, bo_sel_d;
  logic bo_undef_q, bo_undef_d;
  logic qr_q, qr_d;
  logic [2:0] gw_q, gw_d;
  logic [1:0] pol_q, pol_d;
  logic [7:0] idx;
  logic req;
  logic wr;
  logic filt_level;
  logic div_level;
  logic [7:0] status;
  logic [7:0] rd_byte;

  // ****************************************
  // Bus request decode
  // ****************************************
  // A new request is taken only while no answer is pending
  assign req = cyc_i & stb_i & ~ack_q;
  // Write lands on the edge at which the master samples ack,
  // so a request dropped before ack never touches a trim byte
  // Only lane 0 carries trim data; other lanes are ignored
  assign wr = cyc_i & stb_i & we_i & sel_i[0] & ack_q;
  assign idx = adr_i[9:2];

  // ****************************************
  // Bus handshake
  // ****************************************
  always_comb begin
    ack_d = req;
    rdata_d = rdata_q;
    if (req) begin
      rdata_d = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else if (ce_i) begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Read multiplexer
  // ****************************************
  always_comb begin
    status = 8'h00;
    status[TOB_ST_BO_UNDEF] = bo_undef_q;
    status[TOB_ST_FILT] = filt_level;
    status[TOB_ST_OUT] = div_level;
    status[TOB_ST_POL_LSB +: 2] = pol_q;
    unique case (idx)
      TOB_IDX_ADC_REF: rd_byte = adc_ref_q;
      TOB_IDX_ADC_CMP: rd_byte = adc_cmp_q;
      TOB_IDX_OSC: rd_byte = osc_q;
      TOB_IDX_BROWNOUT: rd_byte = bo_q;
      TOB_IDX_CLK_FLT: rd_byte = flt_q;
      TOB_IDX_STATUS: rd_byte = status;
      default: rd_byte = 8'h00;
    endcase
  end

  // ****************************************
  // Trim byte storage
  // ****************************************
  always_comb begin
    adc_ref_d = adc_ref_q;
    adc_cmp_d = adc_cmp_q;
    osc_d = osc_q;
    bo_d = bo_q;
    flt_d = flt_q;
    if (wr) begin
      unique case (idx)
        TOB_IDX_ADC_REF: adc_ref_d = dat_i[7:0];
        // Reserved byte stays writable; software is trusted to leave it
        TOB_IDX_ADC_CMP: adc_cmp_d = dat_i[7:0];
        TOB_IDX_OSC: osc_d = dat_i[7:0];
        TOB_IDX_BROWNOUT: bo_d = dat_i[7:0];
        TOB_IDX_CLK_FLT: flt_d = dat_i[7:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_ref_q <= TOB_RST_ADC_REF;
      adc_cmp_q <= TOB_RST_ADC_CMP;
      osc_q <= TOB_RST_OSC;
      bo_q <= TOB_RST_BROWNOUT;
      flt_q <= TOB_RST_CLK_FLT;
    end else if (ce_i) begin
      adc_ref_q <= adc_ref_d;
      adc_cmp_q <= adc_cmp_d;
      osc_q <= osc_d;
      bo_q <= bo_d;
      flt_q <= flt_d;
    end
  end

  // ****************************************
  // Field decode toward analog blocks
  // ****************************************
  always_comb begin
    ref_out_d = adc_ref_q[7:TOB_ADC_REF_LSB];
    cmp_out_d = adc_cmp_q;
    osc_out_d = osc_q;
    bo_sel_d = tob_bo_decode(bo_q[TOB_BO_CODE_MSB:0]);
    bo_undef_d = ~|tob_bo_decode(bo_q[TOB_BO_CODE_MSB:0]);
    qr_d = flt_q[TOB_QR_BIT];
    gw_d = flt_q[TOB_GW_MSB:TOB_GW_LSB];
    pol_d = flt_q[TOB_POL_MSB:0];
  end

  // Decoded fields are registered so analog inputs never see
  // decode hazards from a byte in mid-update
  // Fields driven continuously
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_out_q <= TOB_RST_ADC_REF[7:TOB_ADC_REF_LSB];
      cmp_out_q <= TOB_RST_ADC_CMP;
      osc_out_q <= TOB_RST_OSC;
      bo_sel_q <= tob_bo_decode(TOB_RST_BROWNOUT[TOB_BO_CODE_MSB:0]);
      bo_undef_q <= 1'b0;
      qr_q <= TOB_RST_CLK_FLT[TOB_QR_BIT];
      gw_q <= TOB_RST_CLK_FLT[TOB_GW_MSB:TOB_GW_LSB];
      pol_q <= TOB_RST_CLK_FLT[TOB_POL_MSB:0];
    end else if (ce_i) begin
      ref_out_q <= ref_out_d;
      cmp_out_q <= cmp_out_d;
      osc_out_q <= osc_out_d;
      bo_sel_q <= bo_sel_d;
      bo_undef_q <= bo_undef_d;
      qr_q <= qr_d;
      gw_q <= gw_d;
      pol_q <= pol_d;
    end
  end

  // ****************************************
  // Clock glitch filter path
  // ****************************************
  // Widths below one period still cost a full cycle at 100 MHz
  // Filter on sampled clock
  tob_glitch_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .raw_i(clk_filter_in_i),
    .polarity_i(pol_q),
    .width_sel_i(gw_q),
    .filt_o(filt_level)
  );

  tob_quarter_rate u_divider (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_i(filt_level),
    .quarter_i(qr_q),
    .out_o(div_level)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign ack_o = ack_q;
  assign dat_o = rdata_q;
  assign clk_filter_out_o = div_level;
  assign adc_reference_adjust_value_o = ref_out_q;
  assign adc_comparator_adjust_o = cmp_out_q;
  assign oscillator_adjust_value_o = osc_out_q;
  assign brownout_threshold_sel_o = bo_sel_q;
  assign brownout_code_undefined_o = bo_undef_q;
  assign quarter_rate_select_o = qr_q;
  assign glitch_width_select_o = gw_q;
  assign glitch_filter_polarity_o = pol_q;

endmodule

// >>> tob_trim_bank_asserts.sv
`timescale 1ns/1ps
// ****************
// Checker
// ****************
module tob_trim_bank_asserts
  import tob_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [4:0] adc_reference_adjust_value_o,
  input wire logic [7:0] oscillator_adjust_value_o,
  input wire logic [5:0] brownout_threshold_sel_o,
  input wire logic brownout_code_undefined_o,
  input wire logic quarter_rate_select_o,
  input wire logic [2:0] glitch_width_select_o,
  input wire logic [1:0] glitch_filter_polarity_o
);
  logic take;
  logic wr;
  assign take = cyc_i & stb_i & ~ack_o & ce_i;
  assign wr = cyc_i & stb_i & we_i & sel_i[0] & ack_o & ce_i;
  // Decoded fields lag the write by two edges
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_lat; take |=> ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_hi; ack_o |-> dat_o[31:8] == 24'h0; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper data set");
  property p_ref;
    wr && adr_i[9:2] == TOB_IDX_ADC_REF |-> ##2 adc_reference_adjust_value_o == $past(dat_i[7:3], 2);
  endproperty
  a_ref: assert property (p_ref) else $error("ref adjust wrong");
  property p_osc;
    wr && adr_i[9:2] == TOB_IDX_OSC |-> ##2 oscillator_adjust_value_o == $past(dat_i[7:0], 2);
  endproperty
  a_osc: assert property (p_osc) else $error("osc adjust wrong");
  property p_bo;
    wr && adr_i[9:2] == TOB_IDX_BROWNOUT
      |-> ##2 brownout_code_undefined_o == ($past(dat_i[2:1], 2) == 2'h1);
  endproperty
  a_bo: assert property (p_bo) else $error("undefined flag wrong");
  property p_flt;
    wr && adr_i[9:2] == TOB_IDX_CLK_FLT |-> ##2 {quarter_rate_select_o, glitch_width_select_o,
      glitch_filter_polarity_o} == {$past(dat_i[7], 2), $past(dat_i[5:3], 2), $past(dat_i[1:0], 2)};
  endproperty
  a_flt: assert property (p_flt) else $error("filter fields wrong");
  property p_hold;
    !$past(wr, 2) && !$past(rst_i) |-> $stable({adc_reference_adjust_value_o,
      oscillator_adjust_value_o, brownout_threshold_sel_o, quarter_rate_select_o,
      glitch_width_select_o, glitch_filter_polarity_o});
  endproperty
  a_hold: assert property (p_hold) else $error("trim output moved");
endmodule

bind tob_trim_bank tob_trim_bank_asserts u_chk (.*);

// >>> tob_trim_bank_bench.sv
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module tob_trim_bank_bench;
  import tob_pkg::*;
  logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, fin_i, fout, ack_o, undef, quarter;
  logic [9:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [4:0] ref_v;
  logic [7:0] cmp_v, osc_v;
  logic [5:0] bo_sel;
  logic [2:0] width;
  logic [1:0] pol;
  int n_fail, samples_checked;
  // Expected {selection, undefined} per code
  logic [6:0] bo_exp [8] = '{7'h04, 7'h02, 7'h01, 7'h01, 7'h40, 7'h20, 7'h10, 7'h08};

  tob_trim_bank DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .clk_filter_in_i(fin_i), .clk_filter_out_o(fout), .adc_reference_adjust_value_o(ref_v),
    .adc_comparator_adjust_o(cmp_v), .oscillator_adjust_value_o(osc_v),
    .brownout_threshold_sel_o(bo_sel), .brownout_code_undefined_o(undef),
    .quarter_rate_select_o(quarter), .glitch_width_select_o(width),
    .glitch_filter_polarity_o(pol));

  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end

  task finish_test;
    $display("n_fail=%0d samples_checked=%0d", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task wb(input logic w, input logic [9:0] a, input logic [7:0] d, input logic s);
    int i;
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= {24'h0, d}; sel_i <= {3'h0, s};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'h1 && i < 20);
    if (i >= 20) begin
      n_fail++;
      $display("unexpected at %0t: no ack", $time);
      finish_test;
    end
    q = dat_o;
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
  endtask

  task wr(input logic [9:0] a, input logic [7:0] d);
    wb(1, a, d, 1);
    repeat (2) @(posedge clk_i);
  endtask

  task rd(input logic [9:0] a, input logic [31:0] e);
    wb(0, a, 8'h00, 1);
    chk(q, e);
  endtask

  // Reset contents and outputs
  task t_reset;
    chk({ref_v, cmp_v, osc_v}, {5'h1F, 8'hFF, 8'h80});
    chk({bo_sel, undef, quarter, width, pol}, {6'h20, 7'h00});
    rd(10'h080, 32'hFF); rd(10'h084, 32'hFF); rd(10'h088, 32'h80);
    rd(10'h08C, 32'hFC); rd(10'h098, 32'h44); rd(10'h09C, 32'h0);
  endtask

  // Plain writes, disabled lane, unmapped place
  task t_rw;
    wr(10'h080, 8'hAF); wr(10'h084, 8'hFF); wr(10'h088, 8'h3C);
    chk({ref_v, cmp_v, osc_v}, {5'h15, 8'hFF, 8'h3C});
    wb(1, 10'h088, 8'hC3, 0);
    wr(10'h090, 8'h12);
    chk(osc_v, 8'h3C);
    rd(10'h088, 32'h3C); rd(10'h080, 32'hAF); rd(10'h090, 32'h0);
  endtask

  task t_bo;
    for (int c = 0; c < 8; c++) begin
      wr(10'h08C, {5'h1F, c[2:0]});
      chk({bo_sel, undef}, bo_exp[c]);
      rd(10'h09C, {31'h0, bo_exp[c][0]});
    end
  endtask

  task t_flt;
    for (int i = 0; i < 8; i++) begin
      wr(10'h098, {i[2], 1'h1, i[2:0], 1'h1, i[1:0]});
      chk({quarter, width, pol}, {i[2], i[2:0], i[1:0]});
      rd(10'h098, {24'h0, i[2], 1'h1, i[2:0], 1'h1, i[1:0]});
    end
  endtask

  // Square wave, 16 input periods; count output rises
  task sq(input logic [7:0] cfg, input int e);
    int n;
    logic last;
    fin_i <= 0;
    wr(10'h098, cfg);
    repeat (8) @(posedge clk_i);
    n = 0;
    last = fout;
    for (int i = 0; i < 72; i++) begin
      fin_i <= (i < 64) ? i[1] : 1'h0;
      @(posedge clk_i);
      if (fout === 1'h1 && last === 1'h0) n++;
      last = fout;
    end
    chk(n, e);
  endtask

  // One pulse away from base level; count output changes
  task gl(input logic [7:0] cfg, input logic base, input int len, input int e);
    int n;
    logic last;
    fin_i <= base;
    wr(10'h098, cfg);
    repeat (8) @(posedge clk_i);
    n = 0;
    last = fout;
    for (int i = 0; i < len + 12; i++) begin
      fin_i <= (i < len) ? ~base : base;
      @(posedge clk_i);
      if (fout !== last) n++;
      last = fout;
    end
    chk(n, e);
  endtask

  // Clock enable low freezes the filter path
  task t_ce;
    ce_i <= 0;
    fin_i <= 1;
    repeat (6) @(posedge clk_i);
    chk(fout, 1'h0);
    ce_i <= 1;
    repeat (4) @(posedge clk_i);
    chk(fout, 1'h1);
    fin_i <= 0;
    repeat (4) @(posedge clk_i);
  endtask

  task do_reset;
    rst_i <= 1;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
  endtask

  initial begin
    rst_i = 1; cyc_i = 0; stb_i = 0; we_i = 0; adr_i = 0; sel_i = 0; dat_i = 0; fin_i = 0;
    ce_i = 1;
    n_fail = 0;
    samples_checked = 0;
    do_reset;
    t_reset;
    t_rw;
    t_bo;
    t_flt;
    sq(8'h44, 16);
    sq(8'hC4, 4);
    gl(8'h7E, 0, 2, 0); gl(8'h7E, 0, 4, 2); gl(8'h7E, 1, 1, 2);
    gl(8'h7D, 1, 2, 0); gl(8'h7C, 0, 1, 2); gl(8'h47, 0, 1, 2);
    gl(8'h5E, 0, 1, 0); gl(8'h5E, 0, 2, 2);
    // Second reset in mid-run
    do_reset;
    t_reset;
    t_ce;
    finish_test;
  end
endmodule
